// ===== rtl/emi_defs.svh
// Named constants for the zoned external memory interface master.
// Assumes inclusion by bare name from every file that needs them.
`ifndef EMI_DEFS_SVH
`define EMI_DEFS_SVH

// Bus and counter widths
`define EMI_ADDR_W       20
`define EMI_DATA_W       32
`define EMI_CYC_W        4
`define EMI_EL_W         8

// Timing clock is clk_sys divided by two
`define EMI_TIM_DIV_LAST 1'h1
`define EMI_TIM_DIV_ZERO 1'h0

// Asynchronous ready samples this many timing periods early
`define EMI_ASYNC_EARLY  2'h2
`define EMI_WAIT_NONE    2'h0

// Ready-mode encodings
`define EMI_RDY_SYNC     1'h0
`define EMI_RDY_ASYNC    1'h1

`endif

// ===== rtl/emi_pkg.sv
// Types shared by the external memory interface master.
// Assumes no other package.
package emi_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ALIGN,
        ST_LEAD,
        ST_ACTIVE,
        ST_TRAIL
    } emi_state_t;

endpackage

// ===== rtl/emi_sync3.sv
// Three-stage synchroniser with agreement filter.
// Assumes a level input from outside the clk_sys domain.
`timescale 1ns/1ns

module emi_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);

    logic s1_reg, s2_reg, s3_reg, out_reg;
    logic out_next;

    // Only the second and third stages are compared; the first may be metastable
    always_comb
    begin
        out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_reg  <= RST_VAL;
            s2_reg  <= RST_VAL;
            s3_reg  <= RST_VAL;
            out_reg <= RST_VAL;
        end
        else
        begin
            s1_reg  <= async_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;

endmodule // emi_sync3

// ===== rtl/emi_ext_mem_if.sv
// Master side of a zoned external memory bus with ready stretching.
// Assumes one request port on clk_sys and asynchronous memories outside.
`timescale 1ns/1ns
`include "emi_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module emi_ext_mem_if #(
    parameter int ADDR_W = `EMI_ADDR_W,
    parameter int DATA_W = `EMI_DATA_W,
    parameter int CYC_W  = `EMI_CYC_W,
    parameter int EL_W   = `EMI_EL_W
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // Request side
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   done_pulse,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   busy,
    // Zone timing configuration
    input  wire logic [CYC_W-1:0]  rd_lead_cycles,
    input  wire logic [CYC_W-1:0]  rd_active_cycles,
    input  wire logic [CYC_W-1:0]  rd_trail_cycles,
    input  wire logic [CYC_W-1:0]  wr_lead_cycles,
    input  wire logic [CYC_W-1:0]  wr_active_cycles,
    input  wire logic [CYC_W-1:0]  wr_trail_cycles,
    input  wire logic              ready_enable,
    input  wire logic              ready_sample_mode,
    input  wire logic              double_timing_sel,
    input  wire logic              half_bus_clk,
    input  wire logic              bus_32bit_mode,
    // External bus
    output logic                   bus_out_clk,
    output logic                   zone_cs_n,
    output logic                   rd_strobe_n,
    output logic                   wr_strobe_lo_n,
    output logic                   wr_strobe_hi_n,
    output logic                   rd_not_wr,
    output logic [ADDR_W-1:0]      addr_bus,
    input  wire logic [DATA_W-1:0] data_bus_in,
    output logic [DATA_W-1:0]      data_bus_out,
    output logic                   data_bus_oe_n,
    input  wire logic              ext_ready
);
    import emi_pkg::*;

    if (ADDR_W < 2 || DATA_W < 1 || CYC_W < 2 || EL_W < CYC_W + 2)
    begin : g_bad_params
        $error("emi_ext_mem_if: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready synchroniser and timing clock

    logic rdy_sync;

    emi_sync3 #(.RST_VAL(1'b1)) u_rdy_sync (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in (ext_ready),
        .sync_out (rdy_sync)
    );

    emi_state_t             state_reg, state_next;
    logic                   div_reg, div_next, hp_reg, hp_next, tick;
    logic                   clk_reg, clk_next;
    logic [EL_W-1:0]        el_reg, el_next, el_inc, la_w, pt_w, lead_w;
    logic [CYC_W:0]         lead_reg, lead_next, trail_reg, trail_next;
    logic [CYC_W:0]         tcnt_reg, tcnt_next, lead_eff, act_eff, trail_eff;
    logic [CYC_W+1:0]       la_reg, la_next;
    logic                   wr_reg, wr_next, use_reg, use_next, mode_reg, mode_next;
    logic                   got_reg, got_next, rdy_hit, act_done, leadact;
    logic [1:0]             wait_reg, wait_next, wait_eff;
    logic [ADDR_W-1:0]      pend_reg, pend_next, addr_reg, addr_next;
    logic [DATA_W-1:0]      wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic                   cs_reg, cs_next, rd_reg, rd_next, we_reg, we_next;
    logic                   hi_reg, hi_next, rnw_reg, rnw_next, oe_reg, oe_next;
    logic                   lsb_reg, lsb_next, done_reg, done_next, acc_n, act_n;

    // Timing clock is a tick every second clk_sys edge
    assign tick    = (div_reg == `EMI_TIM_DIV_LAST);
    assign div_next = tick ? `EMI_TIM_DIV_ZERO : ~div_reg;
    assign hp_next  = tick ? ~hp_reg : hp_reg;
    // Rising edge of bus_out_clk coincides with a timing period start
    assign clk_next = half_bus_clk ? ~hp_next : (div_next == `EMI_TIM_DIV_ZERO);

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer

    assign leadact  = (state_reg == ST_LEAD) || (state_reg == ST_ACTIVE);
    assign el_inc   = (el_reg == {EL_W{1'b1}}) ? el_reg : el_reg + 1'b1;
    assign la_w     = EL_W'(la_reg);
    assign lead_w   = EL_W'(lead_reg);
    // Async sample point saturates at the access start for very short settings
    assign pt_w     = (mode_reg == `EMI_RDY_ASYNC)
                    ? ((la_w > EL_W'(`EMI_ASYNC_EARLY)) ? la_w - EL_W'(`EMI_ASYNC_EARLY)
                                                        : '0)
                    : la_w;
    assign rdy_hit  = leadact && use_reg && !got_reg && (el_inc >= pt_w) && rdy_sync;
    assign wait_eff = rdy_hit ? ((mode_reg == `EMI_RDY_ASYNC) ? `EMI_ASYNC_EARLY
                                                              : `EMI_WAIT_NONE)
                              : wait_reg;
    assign act_done = (el_inc >= la_w) &&
                      (!use_reg || ((got_reg || rdy_hit) && wait_eff == `EMI_WAIT_NONE));
    assign lead_eff  = double_timing_sel ? {(req_write ? wr_lead_cycles : rd_lead_cycles), 1'b0}
                                         : {1'b0, (req_write ? wr_lead_cycles : rd_lead_cycles)};
    assign act_eff   = double_timing_sel ? {(req_write ? wr_active_cycles : rd_active_cycles), 1'b0}
                                         : {1'b0, (req_write ? wr_active_cycles : rd_active_cycles)};
    assign trail_eff = double_timing_sel ? {(req_write ? wr_trail_cycles : rd_trail_cycles), 1'b0}
                                         : {1'b0, (req_write ? wr_trail_cycles : rd_trail_cycles)};
    assign req_ready = (state_reg == ST_IDLE) && tick;

    always_comb
    begin
        state_next = state_reg;
        el_next    = el_reg;
        tcnt_next  = tcnt_reg;
        lead_next  = lead_reg;
        la_next    = la_reg;
        trail_next = trail_reg;
        wr_next    = wr_reg;
        use_next   = use_reg;
        mode_next  = mode_reg;
        got_next   = got_reg;
        wait_next  = wait_reg;
        pend_next  = pend_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        done_next  = 1'b0;
        unique case (state_reg)
            ST_IDLE:
                if (req_valid && tick)
                begin
                    lead_next  = lead_eff;
                    la_next    = {1'b0, lead_eff} + {1'b0, act_eff};
                    trail_next = trail_eff;
                    wr_next    = req_write;
                    use_next   = ready_enable;
                    mode_next  = ready_sample_mode;
                    got_next   = 1'b0;
                    wait_next  = `EMI_WAIT_NONE;
                    el_next    = '0;
                    pend_next  = req_addr;
                    wdata_next = req_wdata;
                    // Start only where bus_out_clk rises, even just after a rate change
                    state_next = (clk_next && !clk_reg) ? ST_LEAD : ST_ALIGN;
                end
            ST_ALIGN:
                if (tick && clk_next && !clk_reg)
                    state_next = ST_LEAD;
            ST_LEAD, ST_ACTIVE:
                if (tick)
                begin
                    el_next   = el_inc;
                    got_next  = got_reg || rdy_hit;
                    wait_next = (wait_eff != `EMI_WAIT_NONE) ? wait_eff - 2'h1 : wait_eff;
                    if (act_done)
                    begin
                        tcnt_next = '0;
                        if (!wr_reg)
                            rdata_next = data_bus_in;
                        state_next = (trail_reg != '0) ? ST_TRAIL : ST_IDLE;
                        done_next  = (trail_reg == '0);
                    end
                    else if (el_inc >= lead_w)
                        state_next = ST_ACTIVE;
                end
            ST_TRAIL:
                if (tick)
                begin
                    tcnt_next = tcnt_reg + 1'b1;
                    if (tcnt_next >= trail_reg)
                    begin
                        state_next = ST_IDLE;
                        done_next  = 1'b1;
                    end
                end
            default:
                state_next = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin values follow the next state so they change with the timing edge

    always_comb
    begin
        acc_n     = (state_next == ST_LEAD) || (state_next == ST_ACTIVE) ||
                    (state_next == ST_TRAIL);
        act_n     = (state_next == ST_ACTIVE);
        cs_next   = !acc_n;
        rnw_next  = !(acc_n && wr_next);
        rd_next   = !(act_n && !wr_next);
        we_next   = !(act_n && wr_next);
        // Drive from strobe active through trail, release with rd_not_wr
        oe_next   = !(wr_next && (act_n || state_next == ST_TRAIL));
        // Address only moves when an access opens, never in alignment
        addr_next = (state_next == ST_LEAD && state_reg != ST_LEAD) ? pend_next : addr_reg;
        lsb_next  = acc_n ? addr_next[0] : 1'b1;
        hi_next   = bus_32bit_mode ? we_next : lsb_next;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            div_reg   <= 1'b0;
            hp_reg    <= 1'b0;
            clk_reg   <= 1'b0;
            el_reg    <= '0;
            tcnt_reg  <= '0;
            lead_reg  <= '0;
            la_reg    <= '0;
            trail_reg <= '0;
            wr_reg    <= 1'b0;
            use_reg   <= 1'b0;
            mode_reg  <= 1'b0;
            got_reg   <= 1'b0;
            wait_reg  <= '0;
            pend_reg  <= '0;
            addr_reg  <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            cs_reg    <= 1'b1;
            rd_reg    <= 1'b1;
            we_reg    <= 1'b1;
            hi_reg    <= 1'b1;
            rnw_reg   <= 1'b1;
            oe_reg    <= 1'b1;
            lsb_reg   <= 1'b1;
            done_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            div_reg   <= div_next;
            hp_reg    <= hp_next;
            clk_reg   <= clk_next;
            el_reg    <= el_next;
            tcnt_reg  <= tcnt_next;
            lead_reg  <= lead_next;
            la_reg    <= la_next;
            trail_reg <= trail_next;
            wr_reg    <= wr_next;
            use_reg   <= use_next;
            mode_reg  <= mode_next;
            got_reg   <= got_next;
            wait_reg  <= wait_next;
            pend_reg  <= pend_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            cs_reg    <= cs_next;
            rd_reg    <= rd_next;
            we_reg    <= we_next;
            hi_reg    <= hi_next;
            rnw_reg   <= rnw_next;
            oe_reg    <= oe_next;
            lsb_reg   <= lsb_next;
            done_reg  <= done_next;
        end
    end

    assign bus_out_clk    = clk_reg;
    assign zone_cs_n      = cs_reg;
    assign rd_strobe_n    = rd_reg;
    assign wr_strobe_lo_n = we_reg;
    assign wr_strobe_hi_n = hi_reg;
    assign rd_not_wr      = rnw_reg;
    assign addr_bus       = {addr_reg[ADDR_W-1:1], lsb_reg};
    assign data_bus_out   = wdata_reg;
    assign data_bus_oe_n  = oe_reg;
    assign rd_data        = rdata_reg;
    assign done_pulse     = done_reg;
    assign busy           = (state_reg != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    AST_START_RISE: assert property ($fell(zone_cs_n) |-> $rose(bus_out_clk))
        else $error("access did not start on a bus clock rising edge");
    AST_ALIGN_IDLE: assert property ((state_reg == ST_ALIGN) |->
        zone_cs_n && rd_strobe_n && wr_strobe_lo_n && rd_not_wr && data_bus_oe_n)
        else $error("control line active during alignment");
    AST_ADDR_HOLD: assert property (zone_cs_n && $past(zone_cs_n) |->
        addr_bus[0] && $stable(addr_bus[ADDR_W-1:1]))
        else $error("address moved or low bit low while inactive");
    AST_HI_STROBE: assert property (
        ($past(bus_32bit_mode) |-> wr_strobe_hi_n == wr_strobe_lo_n) and
        (!$past(bus_32bit_mode) |-> wr_strobe_hi_n == addr_bus[0]))
        else $error("upper write strobe pin has wrong function");
    AST_NO_READY: assert property (tick && leadact && !use_reg && el_inc >= la_w |=>
        state_reg != ST_ACTIVE)
        else $error("access stretched with ready disabled");
    AST_SYNC_FIRST: assert property (tick && leadact && use_reg && !mode_reg && !got_reg &&
        rdy_sync && el_inc == la_w |=> state_reg inside {ST_TRAIL, ST_IDLE})
        else $error("synchronous ready high did not end active period");
    AST_EXTEND: assert property (tick && leadact && use_reg && !got_reg && !rdy_sync &&
        el_inc >= la_w |=> state_reg == ST_ACTIVE ##1 state_reg == ST_ACTIVE)
        else $error("low ready did not stretch active period");
    AST_ASYNC_EARLY: assert property (tick && leadact && use_reg && mode_reg && !got_reg &&
        rdy_sync && el_inc == pt_w && la_w > EL_W'(`EMI_ASYNC_EARLY) |=>
        ##4 state_reg inside {ST_TRAIL, ST_IDLE})
        else $error("asynchronous ready did not end two periods after sample");
    AST_MODE_SEL: assert property (rdy_hit && tick |=>
        wait_reg == (mode_reg ? 2'h1 : 2'h0))
        else $error("ready mode delay wrong");
    AST_WDATA_DRIVE: assert property ($fell(wr_strobe_lo_n) |-> !data_bus_oe_n)
        else $error("write data not driven at strobe");
    AST_RELEASE: assert property ($rose(rd_not_wr) |-> data_bus_oe_n)
        else $error("data bus still driven after write");
    AST_STROBE_IN_CS: assert property (!rd_strobe_n || !wr_strobe_lo_n |-> !zone_cs_n)
        else $error("strobe outside chip select");
    AST_IDLE_LINES: assert property ((state_reg == ST_IDLE) |->
        rd_not_wr && rd_strobe_n && wr_strobe_lo_n && zone_cs_n)
        else $error("bus not idle with no access");

endmodule // emi_ext_mem_if

// ===== verification/emi_mem_model.sv
// Behavioural asynchronous memory with a ready stretch on the far side.
// Assumes active-low strobes; stalls are timed by a free local 64 ns clock.
`timescale 1ns/1ns

module emi_mem_model (
    // Bus from the master
    input  wire logic        zone_cs_n,
    input  wire logic        rd_strobe_n,
    input  wire logic        wr_strobe_lo_n,
    input  wire logic [19:0] addr_bus,
    input  wire logic [31:0] data_bus_out,
    input  wire logic        data_bus_oe_n,
    // Stall length in local clock periods
    input  wire logic [3:0]  wait_cnt,
    // Answers
    output logic [31:0]      data_bus_in,
    output logic             ext_ready
);
    logic        lclk = 1'b0;
    logic [3:0]  cnt  = 4'h0;
    logic [31:0] last = 32'h0;
    logic [31:0] mem [16];

    // Odd start offset keeps the stall clock unrelated to the master clock
    initial
    begin
        #7;
        forever #32 lclk = ~lclk;
    end

    always @(posedge lclk or posedge zone_cs_n)
        if (zone_cs_n)
            cnt <= 4'h0;
        else if (cnt < wait_cnt)
            cnt <= cnt + 4'h1;

    // A stalling device keeps ready low while deselected too, so the low level
    // has crossed the master's synchroniser before an early first sample
    assign ext_ready = (wait_cnt == 4'h0) | (!zone_cs_n & (cnt >= wait_cnt));

    // Once the strobe is released the old word is gone: show its inverse
    assign data_bus_in = rd_strobe_n ? ~last : mem[addr_bus[3:0]];

    always @(negedge rd_strobe_n)
        last <= mem[addr_bus[3:0]];

    // Written while the strobe is low, so strobe, chip select and enable
    // releasing on one edge cannot race the capture
    always @*
        if (!wr_strobe_lo_n && !zone_cs_n && !data_bus_oe_n)
            mem[addr_bus[3:0]] = data_bus_out;
endmodule // emi_mem_model

// ===== verification/tb_emi_ext_mem_if.sv
// Self-checking bench for the external memory interface master.
// Assumes the memory model answers on the far side of the bus.
`timescale 1ns/1ns

module tb_emi_ext_mem_if;
    logic        clk_sys = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [31:0] req_wdata = 32'h0, rd_data, data_bus_in, data_bus_out;
    logic [3:0]  rd_lead_cycles = 4'h1, rd_active_cycles = 4'h1, rd_trail_cycles = 4'h1;
    logic [3:0]  wr_lead_cycles = 4'h1, wr_active_cycles = 4'h1, wr_trail_cycles = 4'h1;
    logic        ready_enable = 1'b0, ready_sample_mode = 1'b0, double_timing_sel = 1'b0;
    logic        half_bus_clk = 1'b0, bus_32bit_mode = 1'b1;
    logic        req_ready, done_pulse, busy, bus_out_clk, zone_cs_n, rd_strobe_n;
    logic        wr_strobe_lo_n, wr_strobe_hi_n, rd_not_wr, data_bus_oe_n, ext_ready;
    logic [19:0] addr_bus, addr_e;
    logic [3:0]  stall_len = 4'h0;
    logic        st, p_st, p_cs, p_rdy, p_boc, boc_ok, oe_s, hi_s, rnw_s, oe_e;
    logic [31:0] dat_s, dat_t;
    int          cyc = 0, t_cs0, t_st0, t_st1, t_cs1, t_rdy1, fail_count = 0, num_checks = 0;

    always #2 clk_sys = ~clk_sys;

    emi_ext_mem_if dut (.clk_sys, .rstn, .req_valid, .req_ready, .req_write, .req_addr,
        .req_wdata, .done_pulse, .rd_data, .busy, .rd_lead_cycles, .rd_active_cycles,
        .rd_trail_cycles, .wr_lead_cycles, .wr_active_cycles, .wr_trail_cycles,
        .ready_enable, .ready_sample_mode, .double_timing_sel, .half_bus_clk,
        .bus_32bit_mode, .bus_out_clk, .zone_cs_n, .rd_strobe_n, .wr_strobe_lo_n,
        .wr_strobe_hi_n, .rd_not_wr, .addr_bus, .data_bus_in, .data_bus_out,
        .data_bus_oe_n, .ext_ready);

    emi_mem_model mem (.zone_cs_n, .rd_strobe_n, .wr_strobe_lo_n, .addr_bus,
        .data_bus_out, .data_bus_oe_n, .wait_cnt(stall_len), .data_bus_in, .ext_ready);

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Edge recorder, sampled mid-cycle where registered pins have settled
    always @(negedge clk_sys)
    begin
        cyc = cyc + 1;
        st = rd_strobe_n & wr_strobe_lo_n;
        if (rstn && zone_cs_n === 1'b1)
            check("idle", {rd_strobe_n, wr_strobe_lo_n, rd_not_wr, addr_bus[0]}, 4'hF);
        if (p_cs && !zone_cs_n)
        begin
            t_cs0 = cyc;
            boc_ok = bus_out_clk & !p_boc;
        end
        if (p_st && !st)
        begin
            t_st0 = cyc;
            {oe_s, dat_s, hi_s, rnw_s} = {data_bus_oe_n, data_bus_out, wr_strobe_hi_n, rd_not_wr};
        end
        if (!p_st && st)
        begin
            t_st1 = cyc;
            dat_t = data_bus_out;
        end
        if (!p_cs && zone_cs_n)
        begin
            t_cs1 = cyc;
            {oe_e, addr_e} = {data_bus_oe_n, addr_bus};
        end
        if (!p_rdy && ext_ready && !zone_cs_n)
            t_rdy1 = cyc;
        {p_cs, p_st, p_rdy, p_boc} = {zone_cs_n, st, ext_ready, bus_out_clk};
    end

    // One access; f packs ready enable, ready mode, double timing, half clock, 32-bit mode
    task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d,
                       input logic [3:0] l, ac, tr, input logic [4:0] f, input logic [3:0] wt);
        int k;
        int n;
        @(negedge clk_sys);
        k = f[2] ? 2 : 1;
        {ready_enable, ready_sample_mode, double_timing_sel, half_bus_clk, bus_32bit_mode} = f;
        {rd_lead_cycles, rd_active_cycles, rd_trail_cycles} = {l, ac, tr};
        {wr_lead_cycles, wr_active_cycles, wr_trail_cycles} = {l, ac, tr};
        {stall_len, req_write, req_addr, req_wdata, req_valid} = {wt, w, a, d, 1'b1};
        t_rdy1 = 0;
        n = 0;
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(negedge clk_sys);
            n++;
        end
        check("accept", req_ready, 1);
        @(negedge clk_sys);
        req_valid = 1'b0;
        check("busy", busy, 1);
        n = 0;
        while (done_pulse !== 1'b1 && n < 400)
        begin
            @(negedge clk_sys);
            n++;
        end
        check("done", {done_pulse, busy}, 2'b10);
        @(negedge clk_sys);
        check("lead", t_st0 - t_cs0, 2 * k * l);
        if (wt == 0 || !f[4])
            check("active", t_st1 - t_st0, 2 * k * ac);
        else
            check("stretch", (t_st1 - t_st0 > 2 * k * ac) && (t_st1 >= t_rdy1), 1);
        check("trail", t_cs1 - t_st1, 2 * k * tr);
        check("start_edge", boc_ok, 1);
        check("hi_strobe", hi_s, f[0] ? !w : a[0]);
        check("rnw", rnw_s, !w);
        check("last_addr", addr_e, {a[19:1], 1'b1});
        if (w)
        begin
            check("wdata", {oe_s, dat_s}, {1'b0, d});
            check("release", oe_e, 1);
            if (tr != 0)
                check("wdata_hold", dat_t, d);
        end
        else
            check("rdata", rd_data, d);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
        if (cyc > 6000)
        begin
            fail_count++;
            test_done();
        end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        acc(1'b1, 20'h12345, 32'hA5A5F00F, 4'h1, 4'h1, 4'h1, 5'b00001, 4'h0);
        acc(1'b0, 20'h12345, 32'hA5A5F00F, 4'h1, 4'h1, 4'h1, 5'b00001, 4'h0);
        acc(1'b1, 20'h00ABC, 32'h0F1E2D3C, 4'h2, 4'h3, 4'h2, 5'b00011, 4'h0);
        acc(1'b0, 20'h00ABC, 32'h0F1E2D3C, 4'h1, 4'h2, 4'h1, 5'b00101, 4'h0);
        // Sync and async sampling, each with and without a stall
        for (int i = 0; i < 4; i++)
            acc(1'b0, 20'h12345, 32'hA5A5F00F, 4'h1, 4'h3, 4'h1, {1'b1, i[1], 3'b001},
                i[0] ? 4'h2 : 4'h0);
        acc(1'b0, 20'h12345, 32'hA5A5F00F, 4'h1, 4'h3, 4'h1, 5'b00001, 4'h2);
        acc(1'b1, 20'h00003, 32'h5A5A0FF0, 4'h1, 4'h1, 4'h0, 5'b00000, 4'h0);
        acc(1'b0, 20'h00003, 32'h5A5A0FF0, 4'h3, 4'h1, 4'h1, 5'b00010, 4'h0);
        test_done();
    end
endmodule // tb_emi_ext_mem_if
